// file: hdl/eeprom_ctrl_defines.svh
// Purpose: named offsets, fields and timing for the eeprom control block
// Assumes: 8-bit special function register bus
// Notes:   included by the design module, the checker and the bench
`ifndef EEPROM_CTRL_DEFINES_SVH
`define EEPROM_CTRL_DEFINES_SVH
`define CTRL_ADDR        8'hD2
`define KEY_MSB          7
`define KEY_LSB          4
`define SPACE_BIT        1
`define BUSY_BIT         0
`define KEY_FIRST        4'h5
`define KEY_SECOND       4'hA
`define CTRL_RESET       8'h00
`define PROG_TIME_US     10
`define CLK_MHZ          25
`define PAGE_BYTES       128
`endif

// file: hdl/eeprom_ctrl_pkg.sv
// Purpose: shared types for the eeprom control block
// Assumes: defines header present
// Notes:   unlock sequencer states are one-hot
package eeprom_ctrl_pkg;
   typedef enum logic [2:0] {
      unlock_idle  = 3'b001,
      unlock_armed = 3'b010,
      unlock_prog  = 3'b100
   } unlock_state_t;
endpackage

// file: hdl/latch_if.sv
// Purpose: carries column latch writes and reads to the latch memory
// Assumes: single clock
// Notes:   one write and one read port per cycle
interface latch_if #(parameter int AW = 7);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [7:0]    wr_data;
   logic [AW-1:0] rd_addr;
   logic [7:0]    rd_data;
   logic          clear;
   modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, clear,
                 input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_addr, clear,
                 output rd_data);
endinterface

// file: hdl/column_latch_mem.sv
// Purpose: column latch buffer, one page of bytes
// Assumes: synchronous reset, read data registered
// Notes:   clear zeroes the read register; stored bytes stay in place
module column_latch_mem #(
   parameter int AW = 7
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   latch_if.mem      lat
);
   localparam int DEPTH = 1 << AW;
   logic [7:0] mem [DEPTH];
   logic [7:0] rd_q;
   logic [7:0] next_rd;

   // -------------------------------------------------
   // storage and registered read
   // -------------------------------------------------
   always_comb begin
      next_rd = mem[lat.rd_addr];
   end

   always_ff @(posedge ref_clk) begin
      if (lat.wr_en) begin
         mem[lat.wr_addr] <= lat.wr_data;
      end
      // a finished program leaves no stale byte on the read port
      if (sys_rst || lat.clear) begin
         rd_q <= 8'h00;
      end else begin
         rd_q <= next_rd;
      end
   end
   assign lat.rd_data = rd_q;
endmodule // column_latch_mem

// file: hdl/eeprom_control_register.sv
// Purpose: eeprom control register, unlock sequencer, busy and routing
// Assumes: cpu sfr bus synchronous to ref_clk; xdata bus one access/cycle
// Notes:   program time is a parameter; nvm array itself is outside
// Functional notes
// [R1] programming starts only after a 5 write then an A write to the key.
// [R2] software never sets bits 3 and 2 and ignores what they read.
// [R3] space select one sends external data moves to the eeprom latches.
// [R4] space select zero sends external data moves to on-chip xram.
// [R5] busy rises as programming begins and holds for the whole operation.
// [R6] busy clears by itself when programming is finished.
// [R7] software writes never change the busy flag.
// [R8] reset clears space select and busy; upper bits read as zero here.
// [R9] the register is byte wide only, no single-bit access path.
// [R10] the two unlock writes must be back to back or launch aborts.
// [R11] while busy the eeprom segment is not readable.
// [R12] the page last used during latch loading is the one programmed.
// [R13] any other key write returns the sequencer to idle; a 5 write while armed keeps it armed.
`include "eeprom_ctrl_defines.svh"
module eeprom_control_register
   import eeprom_ctrl_pkg::*;
#(
   parameter int PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ,
   parameter int PAGE_AW     = 7,
   parameter int ADDR_W      = 11
) (
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic [7:0]        sfr_addr,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   input  wire logic [7:0]        sfr_wdata,
   output logic      [7:0]        sfr_rdata,
   input  wire logic              instr_done,
   input  wire logic              xd_wr,
   input  wire logic              xd_rd,
   input  wire logic [ADDR_W-1:0] xd_addr,
   input  wire logic [7:0]        xd_wdata,
   output logic      [7:0]        xd_rdata,
   output logic                   xram_sel,
   output logic                   xram_wr,
   output logic                   xram_rd,
   output logic      [ADDR_W-1:0] xram_addr,
   output logic      [7:0]        xram_wdata,
   input  wire logic [7:0]        xram_rdata,
   output logic                   nvm_prog_start,
   output logic [ADDR_W-PAGE_AW-1:0] nvm_page,
   output logic      [PAGE_AW-1:0] nvm_col_addr,
   output logic      [7:0]        nvm_col_data,
   output logic                   nvm_col_valid
);
   localparam int CW = $clog2(PROG_CYCLES + 1);
   localparam int PW = ADDR_W - PAGE_AW;

   latch_if #(.AW(PAGE_AW)) lat ();

   column_latch_mem #(.AW(PAGE_AW)) u_latch (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .lat     (lat)
   );

   // -------------------------------------------------
   // control register and unlock sequencer
   // -------------------------------------------------
   unlock_state_t   state;
   unlock_state_t   next_state;
   logic            space_sel;
   logic            next_space_sel;
   logic            busy;
   logic            next_busy;
   logic [CW-1:0]   count;
   logic [CW-1:0]   next_count;
   logic [PAGE_AW:0] dump;
   logic [PAGE_AW:0] next_dump;
   logic            armed_gap;
   logic            next_armed_gap;
   logic            ctrl_wr;
   logic [3:0]      key;

   assign ctrl_wr = sfr_wr && (sfr_addr == `CTRL_ADDR); // [R9]
   assign key     = sfr_wdata[`KEY_MSB:`KEY_LSB];

   // sequencer: a key write other than A or 5 after 5 falls back to idle
   always_comb begin
      next_state     = state;
      next_space_sel = space_sel;
      next_busy      = busy;
      next_count     = count;
      next_dump      = dump;
      next_armed_gap = 1'b0;
      if (ctrl_wr) begin
         next_space_sel = sfr_wdata[`SPACE_BIT]; // bit 0 ignored [R7]
      end
      case (state)
         unlock_idle: begin
            if (ctrl_wr && key == `KEY_FIRST && !busy) begin
               next_state = unlock_armed; // [R1]
            end
         end
         unlock_armed: begin
            // an instruction completed without the second write aborts
            if (ctrl_wr && key == `KEY_SECOND) begin
               next_state = unlock_prog; // [R1]
               next_busy  = 1'b1; // [R5]
               next_count = CW'(PROG_CYCLES);
               next_dump  = '0;
            end else if (ctrl_wr) begin
               next_state = (key == `KEY_FIRST) ? unlock_armed
                                                : unlock_idle; // [R13]
            end else if (instr_done && armed_gap) begin
               next_state = unlock_idle; // [R10]
            end
            next_armed_gap = !ctrl_wr && (armed_gap || instr_done);
         end
         unlock_prog: begin
            // busy holds until the timer expires [R5]
            if (count != '0) begin
               next_count = count - CW'(1);
            end else begin
               next_busy  = 1'b0; // [R6]
               next_state = unlock_idle;
            end
            if (dump[PAGE_AW] == 1'b0) begin
               next_dump = dump + (PAGE_AW+1)'(1);
            end
         end
         default: next_state = unlock_idle;
      endcase
   end

   // the write that arms the sequencer itself ends one instruction
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state     <= unlock_idle;
         space_sel <= 1'b0; // [R8]
         busy      <= 1'b0; // [R8]
         count     <= '0;
         dump      <= '0;
         armed_gap <= 1'b0;
      end else begin
         state     <= next_state;
         space_sel <= next_space_sel;
         busy      <= next_busy;
         count     <= next_count;
         dump      <= next_dump;
         armed_gap <= next_armed_gap;
      end
   end

   // -------------------------------------------------
   // latch loading, page capture and valid tracking
   // -------------------------------------------------
   logic [PW-1:0]      page;
   logic [PW-1:0]      next_page;
   logic [(1<<PAGE_AW)-1:0] valid;
   logic [(1<<PAGE_AW)-1:0] next_valid;
   logic               ee_wr;
   logic               ee_rd;

   assign ee_wr = xd_wr && space_sel && !busy; // [R3]
   assign ee_rd = xd_rd && space_sel && !busy; // [R11]

   // a new page address discards bytes held for the old one
   always_comb begin
      next_page  = page;
      next_valid = valid;
      if (ee_wr) begin
         next_page = xd_addr[ADDR_W-1:PAGE_AW]; // [R12]
         if (xd_addr[ADDR_W-1:PAGE_AW] != page) begin
            next_valid = '0; // [R12]
         end
         next_valid[xd_addr[PAGE_AW-1:0]] = 1'b1;
      end
      // end of programming drops the marks even when a short program
      // time cut the dump stream before the last column
      if (lat.clear) begin
         next_valid = '0; // [R6]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         page  <= '0;
         valid <= '0;
      end else begin
         page  <= next_page;
         valid <= next_valid;
      end
   end

   assign lat.wr_en   = ee_wr;
   assign lat.wr_addr = xd_addr[PAGE_AW-1:0];
   assign lat.wr_data = xd_wdata;
   assign lat.rd_addr = busy ? dump[PAGE_AW-1:0] : xd_addr[PAGE_AW-1:0];
   assign lat.clear   = (state == unlock_prog) && (count == '0); // [R6]

   // -------------------------------------------------
   // registered outputs
   // -------------------------------------------------
   logic [7:0] next_rdata;
   logic       rd_space_q;
   logic       ee_rd_q;
   logic       dump_q;
   logic [PAGE_AW-1:0] dump_addr_q;

   // reserved bits and key read zero; key is write-only by nature
   always_comb begin
      next_rdata = `CTRL_RESET;
      if (sfr_rd && sfr_addr == `CTRL_ADDR) begin
         next_rdata[`SPACE_BIT] = space_sel;
         next_rdata[`BUSY_BIT]  = busy;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sfr_rdata      <= `CTRL_RESET;
         xram_sel       <= 1'b0;
         xram_wr        <= 1'b0;
         xram_rd        <= 1'b0;
         xram_addr      <= '0;
         xram_wdata     <= 8'h00;
         xd_rdata       <= 8'h00;
         nvm_prog_start <= 1'b0;
         nvm_page       <= '0;
         nvm_col_addr   <= '0;
         nvm_col_data   <= 8'h00;
         nvm_col_valid  <= 1'b0;
         dump_q         <= 1'b0;
         dump_addr_q    <= '0;
         rd_space_q     <= 1'b0;
         ee_rd_q        <= 1'b0;
      end else begin
         sfr_rdata      <= next_rdata;
         xram_sel       <= !space_sel; // [R4]
         xram_wr        <= xd_wr && !space_sel; // [R4]
         xram_rd        <= xd_rd && !space_sel; // [R4]
         xram_addr      <= xd_addr;
         xram_wdata     <= xd_wdata;
         // latch data leaves the memory register one edge after the
         // request, so space and gate travel along; busy reads give zero
         rd_space_q     <= space_sel;
         ee_rd_q        <= ee_rd; // [R11]
         xd_rdata       <= rd_space_q ? (ee_rd_q ? lat.rd_data : 8'h00)
                                      : xram_rdata;
         nvm_prog_start <= (state == unlock_armed) &&
                           (next_state == unlock_prog); // [R1]
         nvm_page       <= page;
         // stop one edge before busy drops so no column trails it
         dump_q         <= busy && !dump[PAGE_AW] && (count > CW'(1));
         dump_addr_q    <= dump[PAGE_AW-1:0];
         nvm_col_addr   <= dump_addr_q;
         nvm_col_data   <= lat.rd_data;
         nvm_col_valid  <= dump_q && valid[dump_addr_q];
      end
   end
endmodule // eeprom_control_register

// file: test/xram_model.sv
// Purpose: behavioural on-chip xram seen behind the routing outputs
// Assumes: combinational read while selected
// Notes:   unselected read data churns so a stale value never matches
module xram_model (
   input  wire logic        ref_clk,
   input  wire logic        xram_sel,
   input  wire logic        xram_wr,
   input  wire logic        xram_rd,
   input  wire logic [10:0] xram_addr,
   input  wire logic [7:0]  xram_wdata,
   output logic      [7:0]  xram_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:2047];
   logic [7:0] churn = 8'h5A;
   // store on selected write, churn the idle pattern every cycle
   always @(posedge ref_clk) begin
      churn <= churn + 8'h3B;
      if (xram_sel && xram_wr) mem[xram_addr] <= xram_wdata;
   end
   assign xram_rdata = (xram_sel && xram_rd) ? mem[xram_addr] : churn;
endmodule // xram_model

// file: test/eeprom_ctrl_checker.sv
// Purpose: port checker for the eeprom control register
// Assumes: single clock, synchronous active-high reset
// Notes:   space select and busy are mirrored in helper logic
`include "eeprom_ctrl_defines.svh"
module eeprom_ctrl_checker #(
   parameter int PROG_CYCLES = 250,
   parameter int ADDR_W      = 11
) (
   input wire logic              ref_clk,
   input wire logic              sys_rst,
   input wire logic [7:0]        sfr_addr,
   input wire logic              sfr_wr,
   input wire logic              sfr_rd,
   input wire logic [7:0]        sfr_wdata,
   input wire logic [7:0]        sfr_rdata,
   input wire logic              xd_wr,
   input wire logic              xd_rd,
   input wire logic [ADDR_W-1:0] xd_addr,
   input wire logic [7:0]        xd_rdata,
   input wire logic              xram_wr,
   input wire logic              xram_rd,
   input wire logic [ADDR_W-1:0] xram_addr,
   input wire logic              nvm_prog_start,
   input wire logic              nvm_col_valid
);
   logic hit_w, hit_r, space_m, busy_m;
   int   cnt;
   assign hit_w  = sfr_wr && sfr_addr == `CTRL_ADDR;
   assign hit_r  = sfr_rd && sfr_addr == `CTRL_ADDR;
   assign busy_m = nvm_prog_start || cnt != 0;
   // busy lasts the launch cycle plus the full program count
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         space_m <= 1'b0;
         cnt     <= 0;
      end else begin
         if (hit_w) space_m <= sfr_wdata[`SPACE_BIT];
         if (nvm_prog_start) cnt <= PROG_CYCLES;
         else if (cnt != 0) cnt <= cnt - 1;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   a_launch_cause: assert property (nvm_prog_start |->
      $past(hit_w && sfr_wdata[7:4] == `KEY_SECOND))
      else $error("launch without a second key write");
   a_no_relaunch: assert property (cnt != 0 |-> !nvm_prog_start)
      else $error("launch while programming");
   a_xram_fwd: assert property (xd_wr && !space_m |=>
      xram_wr && xram_addr == $past(xd_addr))
      else $error("xram write not forwarded");
   a_eeprom_route: assert property ((xd_wr || xd_rd) && space_m |=>
      !xram_wr && !xram_rd)
      else $error("eeprom access leaked to xram");
   a_rd_layout: assert property (hit_r |=> sfr_rdata[7:2] == 6'h00
      && sfr_rdata[1] == $past(space_m))
      else $error("control read layout wrong");
   a_rd_busy: assert property (hit_r |=>
      sfr_rdata[0] == $past(busy_m))
      else $error("busy flag read wrong");
   a_dump_busy: assert property (nvm_col_valid |-> busy_m)
      else $error("latch dump outside programming");
   a_busy_read: assert property (xd_rd && space_m && busy_m |->
      ##2 xd_rdata == 8'h00)
      else $error("eeprom readable while busy");
   cover property (nvm_prog_start);
   cover property (nvm_col_valid);
   cover property (xd_wr && !space_m);
endmodule // eeprom_ctrl_checker
bind eeprom_control_register eeprom_ctrl_checker #(
   .PROG_CYCLES(PROG_CYCLES), .ADDR_W(ADDR_W)
) u_chk (.ref_clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
   .sfr_rdata, .xd_wr, .xd_rd, .xd_addr, .xd_rdata, .xram_wr, .xram_rd,
   .xram_addr, .nvm_prog_start, .nvm_col_valid);

// file: test/testbench.sv
// Purpose: self-checking bench for the eeprom control register
// Assumes: short program count, inputs driven on falling edges
// Notes:   expectations come from the bench model arrays below
`include "eeprom_ctrl_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 20;
   logic        ref_clk, sys_rst, sfr_wr, sfr_rd, instr_done, xd_wr, xd_rd;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, xd_rdata;
   logic [7:0]  xram_wdata, xram_rdata, nvm_col_data;
   logic [10:0] xd_addr, xram_addr, a;
   logic        xram_sel, xram_wr, xram_rd, nvm_prog_start, nvm_col_valid;
   logic [3:0]  nvm_page;
   logic [6:0]  nvm_col_addr;
   int          err_total, compares, starts, cyc, space, page, bz, cols;
   int          lat[int], xmem[int];
   eeprom_control_register #(.PROG_CYCLES(P)) u_dut (.ref_clk, .sys_rst,
      .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .instr_done,
      .xd_wr, .xd_rd, .xd_addr, .xd_wdata, .xd_rdata, .xram_sel, .xram_wr,
      .xram_rd, .xram_addr, .xram_wdata, .xram_rdata, .nvm_prog_start,
      .nvm_page, .nvm_col_addr, .nvm_col_data, .nvm_col_valid);
   xram_model u_xram (.ref_clk, .xram_sel, .xram_wr, .xram_rd, .xram_addr,
      .xram_wdata, .xram_rdata);
   // ------------------------------------------------------------
   // drivers and comparison
   // ------------------------------------------------------------
   task automatic drv(logic [4:0] k, logic [7:0] d, logic [10:0] xa);
      @(negedge ref_clk);
      {instr_done, sfr_wr, sfr_rd, xd_wr, xd_rd} = k;
      sfr_addr  = `CTRL_ADDR;
      sfr_wdata = d;
      xd_wdata  = d;
      xd_addr   = xa;
   endtask
   task automatic idle(int n);
      repeat (n) drv(5'h00, 8'h00, 11'h000);
   endtask
   task automatic chk(string nm, logic [10:0] seen, logic [10:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // bits 3 and 2 are always written as zero
   task automatic wr(logic [7:0] d);
      drv(5'h18, d & 8'hF3, 11'h000);
      space = d[1];
   endtask
   task automatic rdreg();
      drv(5'h14, 8'h00, 11'h000);
      idle(1);
      chk("ctrl", {3'h0, sfr_rdata}, 11'(space * 2 + bz));
   endtask
   task automatic xw(logic [10:0] xa, logic [7:0] d);
      drv(5'h12, d, xa);
      if (space) lat[xa[6:0]] = d;
      else xmem[xa] = d;
      if (space) page = xa[10:7];
   endtask
   // both spaces answer one edge after the request edge
   task automatic xr(logic [10:0] xa);
      int exp_rd;
      drv(5'h11, 8'h00, xa);
      idle(2);
      if (space) begin
         exp_rd = bz ? 0 : lat[xa[6:0]];
         chk("latch", {3'h0, xd_rdata}, 11'(exp_rd));
      end else begin
         chk("xram", {3'h0, xd_rdata}, 11'(xmem[xa]));
      end
   endtask
   task automatic final_report();
      if (err_total == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // launch counter and run ceiling
   always @(posedge ref_clk) begin
      cyc++;
      if (nvm_prog_start === 1'b1) starts++;
      if (cyc == 3000) begin
         err_total++;
         final_report();
      end
   end
   // every streamed column must carry the byte last loaded there
   always @(negedge ref_clk) begin
      if (nvm_col_valid === 1'b1) begin
         cols++;
         chk("column", {3'h0, nvm_col_data}, 11'(lat[nvm_col_addr]));
      end
   end
   initial begin
      void'($urandom(32'h3719));
      {instr_done, sfr_wr, sfr_rd, xd_wr, xd_rd} = 5'h00;
      {sfr_addr, sfr_wdata, xd_wdata, xd_addr} = '0;
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      rdreg();
      wr(8'h03);
      rdreg();
      repeat (8) xw(11'($urandom), 8'($urandom));
      foreach (lat[c]) xr({page[3:0], c[6:0]});
      wr(8'h00);
      repeat (8) xw(11'($urandom), 8'($urandom));
      foreach (xmem[x]) xr(11'(x));
      wr(8'h02);
      // a low column, so the short program time still streams it
      a = {4'h9, 7'($urandom) & 7'h0F};
      xw(a, 8'($urandom));
      wr(8'h52);
      wr(8'hA2);
      bz = 1;
      rdreg();
      chk("page", {7'h00, nvm_page}, 11'(page));
      xr(a);
      wr(8'h03);
      wr(8'h52);
      // the next read lands on the last edge at which busy stands
      idle(P - 7);
      rdreg();
      bz = 0;
      rdreg();
      wr(8'hA0);
      wr(8'h50);
      // the first end belongs to the arming write, the second aborts
      repeat (2) drv(5'h10, 8'h00, 11'h000);
      wr(8'hA0);
      wr(8'h50);
      wr(8'h30);
      wr(8'hA0);
      idle(2);
      chk("starts", 11'(starts), 11'd1);
      chk("columns", 11'(cols != 0), 11'd1);
      wr(8'h50);
      wr(8'hA0);
      idle(P + 2);
      chk("starts", 11'(starts), 11'd2);
      rdreg();
      final_report();
   end
endmodule // testbench
